// ---- dv/analog_front_model.sv ----
// Purpose: behavioural analog mux, sample-hold and reference front end
// Assumes: every channel pin is already set up as an analog input
// Notes: the held level only follows the mux while it is connected
`timescale 1ns/1ps
module analog_front_model (
  input wire logic clock_i, // system clock
  input wire logic [4:0] channel_select_i, // mux select
  input wire logic mux_connect_i, // mux inputs connected
  input wire logic [1:0] pos_ref_select_i, // positive reference code
  input wire logic sample_i, // sample-hold tracking
  input wire logic [9:0] dac_i, // trial value
  output logic cmp_o // input at or above trial value
);
  logic [9:0] held_reg = 10'h000;

  // code seen for a channel under a reference; code 10 halves it, code 11 flips alternate bits
  function automatic logic [9:0] level(input logic [4:0] ch, input logic [1:0] rf);
    logic [9:0] v;
    v = {ch, ~ch};
    case (rf)
      2'b10: level = v >> 1;
      2'b11: level = v ^ 10'h2aa;
      default: level = v;
    endcase
  endfunction

  always @(posedge clock_i) begin
    if (sample_i === 1'b1 && mux_connect_i === 1'b1)
      held_reg <= level(channel_select_i, pos_ref_select_i);
  end

  assign cmp_o = (held_reg >= dac_i);
endmodule

// ---- dv/tb_sar_adc_conversion_control.sv ----
// Purpose: register-level bench for the converter control block
// Assumes: front end model answers each trial value at once
// Notes: rc oscillator edge every three system clocks
`timescale 1ns/1ps
module tb_sar_adc_conversion_control;
  import sar_adc_pkg::*;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic sleep_i = 1'b0;
  logic rc_clk_i = 1'b0;
  logic cmp_i;
  logic [7:0] rdata_o;
  logic [4:0] channel_select_o;
  logic mux_connect_o;
  logic [1:0] pos_ref_select_o;
  logic sample_o;
  logic [9:0] dac_o;
  logic wake_o;
  int error_cnt = 0;
  int check_count = 0;
  int rc_cnt = 0;
  int wakes = 0;
  int hc [8] = '{1, 4, 16, 3, 2, 8, 32, 3};
  logic [1:0] refs [4] = '{2'b00, 2'b10, 2'b11, 2'b01};
  logic [7:0] rv;
  logic [15:0] pair;

  always #25 clock_i = ~clock_i;

  always @(posedge clock_i) begin
    rc_cnt <= (rc_cnt + 1) % 3;
    if (rc_cnt == 2) rc_clk_i <= ~rc_clk_i;
    if (wake_o === 1'b1) wakes <= wakes + 1;
  end

  sar_adc_ctrl u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .sleep_i(sleep_i), .rc_clk_i(rc_clk_i), .cmp_i(cmp_i),
    .rdata_o(rdata_o), .channel_select_o(channel_select_o), .mux_connect_o(mux_connect_o),
    .pos_ref_select_o(pos_ref_select_o), .sample_o(sample_o), .dac_o(dac_o), .wake_o(wake_o));
  analog_front_model u_afe (.clock_i(clock_i), .channel_select_i(channel_select_o),
    .mux_connect_i(mux_connect_o), .pos_ref_select_i(pos_ref_select_o), .sample_i(sample_o),
    .dac_i(dac_o), .cmp_o(cmp_i));

  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task automatic give_verdict();
    if (error_cnt == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask

  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  task automatic rd_pair(output logic [15:0] p);
    logic [7:0] h;
    logic [7:0] l;
    reg_rd(res_hi_offset, h);
    reg_rd(res_lo_offset, l);
    p = {h, l};
  endtask

  // poll the status bit until the conversion is over
  task automatic wait_idle(input int limit);
    int n;
    n = 0;
    rv = 8'hff;
    while (rv[go_bit] !== 1'b0 && n < limit) begin
      reg_rd(ctrl0_offset, rv);
      n++;
    end
    if (rv[go_bit] !== 1'b0) begin
      error_cnt++;
      $display("[ERR] status bit expected 0 seen timeout");
      give_verdict();
    end
  endtask

  task automatic convert(input logic [4:0] ch, input logic [7:0] c1);
    reg_wr(ctrl1_offset, c1);
    reg_wr(ctrl0_offset, {1'b0, ch, 2'b01});
    repeat (8) @(posedge clock_i);
    reg_wr(ctrl0_offset, {1'b0, ch, 2'b11});
  endtask

  task automatic sleep_run(input logic [7:0] c1, input logic [7:0] fl, input int exp_wake,
    input logic exp_done);
    int w0;
    w0 = wakes;
    reg_wr(flags_offset, fl);
    sleep_i <= 1'b1;
    convert(5'd6, c1);
    if (exp_done) wait_idle(500);
    else repeat (100) @(posedge clock_i);
    repeat (2) @(posedge clock_i);
    sleep_i <= 1'b0;
    reg_rd(flags_offset, rv);
    check("sleep done", {15'h0000, exp_done}, {15'h0000, rv[done_bit]});
    check("wake pulses", 16'(exp_wake), 16'(wakes - w0));
  endtask

  // partial result: k top bits resolved, the rest copy the last resolved bit
  function automatic logic partial_ok(input logic [9:0] r, input logic [9:0] v);
    logic [9:0] hi;
    logic fill;
    partial_ok = 1'b0;
    for (int k = 0; k <= 10; k++) begin
      hi = 10'h3ff << (10 - k);
      fill = (k == 0) ? 1'b0 : v[10 - k];
      if (((r ^ v) & hi) === 10'h000 && (r & ~hi) === (fill ? ~hi : 10'h000)) partial_ok = 1'b1;
    end
  endfunction

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [4:0] ch;
    logic [1:0] rf;
    logic [7:0] c1;
    time t0;
    int cyc;
    logic ok_bit;
    logic [15:0] exp_v;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    for (int a = 0; a < 6; a++) begin
      reg_rd(3'(a), rv);
      check("reset read", 16'h0000, {8'h00, rv});
    end
    reg_wr(ctrl0_offset, 8'h0a);
    reg_rd(ctrl0_offset, rv);
    check("go while off", 16'h0008, {8'h00, rv});
    check("mux while off", 16'h0000, {15'h0000, mux_connect_o});
    for (int k = 0; k < 8; k++) begin
      ch = 5'(k * 9 + 3);
      rf = refs[k % 4];
      c1 = {k[0], 3'(k), 2'b00, rf};
      reg_wr(flags_offset, 8'h00);
      convert(ch, c1);
      t0 = $time;
      check("channel out", {11'h000, ch}, {11'h000, channel_select_o});
      check("mux on", 16'h0001, {15'h0000, mux_connect_o});
      exp_v = (rf == 2'b01) ? 16'h0000 : {14'h0000, rf};
      check("ref out", exp_v, {14'h0000, pos_ref_select_o});
      wait_idle(3000);
      cyc = int'(($time - t0) / 50);
      ok_bit = (cyc >= 23 * hc[k] - 2) && (cyc <= 24 * hc[k] + 12);
      check("length ok", 16'h0001, {15'h0000, ok_bit});
      reg_rd(flags_offset, rv);
      check("done flag", 16'h0001, {15'h0000, rv[done_bit]});
      rd_pair(pair);
      exp_v = k[0] ? {6'h00, u_afe.level(ch, rf)} : {u_afe.level(ch, rf), 6'h00};
      check("result", exp_v, pair);
    end
    reg_wr(ctrl0_offset, 8'h0f);
    reg_rd(flags_offset, rv);
    check("done held", 16'h0001, {15'h0000, rv[done_bit]});
    wait_idle(3000);
    reg_wr(flags_offset, 8'h00);
    reg_rd(flags_offset, rv);
    check("done cleared", 16'h0000, {15'h0000, rv[done_bit]});
    convert(5'd17, 8'he0);
    repeat (200) @(posedge clock_i);
    reg_wr(ctrl0_offset, {1'b0, 5'd17, 2'b01});
    repeat (3) @(posedge clock_i);
    rd_pair(pair);
    ok_bit = partial_ok(pair[9:0], u_afe.level(5'd17, 2'b00));
    check("partial", 16'h0001, {15'h0000, ok_bit});
    sleep_run(8'hb0, 8'h02, 1, 1'b1);
    sleep_run(8'hb0, 8'h00, 0, 1'b1);
    sleep_run(8'h80, 8'h02, 0, 1'b0);
    give_verdict();
  end
endmodule

// ---- verilog/sar_adc_ctrl.sv ----
// Purpose: control logic of a 10-bit successive-approximation converter
// Assumes: comparator output valid at each bit-period decision
// Notes: registers on a plain strobe port, read data one cycle later
`timescale 1ns/1ps
module sar_adc_ctrl (
  input wire logic clock_i, // system clock
  input wire logic rst_n_i, // async reset
  input wire logic [2:0] addr_i, // register index
  input wire logic [7:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  input wire logic sleep_i, // core is sleeping
  input wire logic rc_clk_i, // internal rc oscillator, sampled
  input wire logic cmp_i, // comparator: input at or above dac level
  output logic [7:0] rdata_o, // read data
  output logic [4:0] channel_select_o, // mux select
  output logic mux_connect_o, // mux inputs connected
  output logic [1:0] pos_ref_select_o, // positive reference code
  output logic sample_o, // sample-hold tracking
  output logic [9:0] dac_o, // trial value for comparator
  output logic wake_o // wake-up request
);
  import sar_adc_pkg::*;

  // ----------------------------------------------------------
  // registers
  // ----------------------------------------------------------
  logic converter_enable_reg;
  logic go_reg;
  logic [4:0] chan_reg;
  logic [1:0] pref_reg;
  logic [2:0] csel_reg;
  logic result_justify_reg;
  logic conv_done_flag_reg;
  logic conv_irq_enable_reg;
  logic [9:0] result_reg;
  logic [9:0] sar_reg;
  logic [4:0] phase_reg;
  logic running_reg;
  logic rc_s1_reg;
  logic rc_s2_reg;
  logic rc_s3_reg;
  logic tick;
  logic finish;
  logic abort;
  logic sleep_kill;
  logic [15:0] pair;
  logic [3:0] bit_idx;

  // partial or full result: unresolved bits copy last resolved bit
  function automatic logic [9:0] fill_partial(input logic [9:0] v, input logic [3:0] n);
    logic [9:0] r;
    r = v;
    for (int i = 0; i < conv_bits; i++) begin
      if (i < (conv_bits - int'(n))) begin
        r[i] = (n == 4'd0) ? 1'b0 : v[conv_bits - int'(n)];
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] justify(input logic [9:0] v, input logic right);
    justify = right ? {6'h00, v} : {v, 6'h00};
  endfunction

  // ----------------------------------------------------------
  // rc clock synchroniser
  // ----------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rc_s1_reg <= 1'b0;
      rc_s2_reg <= 1'b0;
      rc_s3_reg <= 1'b0;
    end else begin
      rc_s1_reg <= rc_clk_i;
      rc_s2_reg <= rc_s1_reg;
      rc_s3_reg <= rc_s2_reg;
    end
  end

  sar_clock_gen u_clk (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .csel_i(csel_reg),
    .rc_tick_i(rc_s2_reg ^ rc_s3_reg), // R20
    .run_i(running_reg),
    .tick_o(tick)
  );

  // ----------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------
  assign bit_idx = phase_reg[4:1];
  assign finish = running_reg && tick && (phase_reg == 5'(half_periods - 1)); // R07
  assign abort = running_reg && wr_i && (addr_i == ctrl0_offset) && !wdata_i[go_bit]; // R18
  assign sleep_kill = running_reg && sleep_i && (csel_reg[1:0] != 2'b11); // R13

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      running_reg <= 1'b0;
      phase_reg <= 5'h00;
      sar_reg <= 10'h000;
    end else if (!converter_enable_reg || abort || sleep_kill || finish) begin
      running_reg <= 1'b0;
      phase_reg <= 5'h00;
    end else if (!running_reg && go_reg) begin
      running_reg <= 1'b1; // R16
      phase_reg <= 5'h00;
      sar_reg <= 10'h000;
    end else if (running_reg && tick) begin
      phase_reg <= phase_reg + 5'h01;
      // odd half periods after the sample resolve one bit each
      if (phase_reg[0] && bit_idx >= 4'd1 && bit_idx <= 4'd10) begin
        sar_reg[conv_bits - int'(bit_idx)] <= cmp_i; // R01
      end
    end
  end

  // ----------------------------------------------------------
  // register file
  // ----------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      converter_enable_reg <= 1'b0;
      go_reg <= 1'b0;
      chan_reg <= 5'h00;
      pref_reg <= 2'b00;
      csel_reg <= 3'b000;
      result_justify_reg <= 1'b0;
      conv_irq_enable_reg <= 1'b0;
    end else begin
      if (wr_i && addr_i == ctrl0_offset) begin
        converter_enable_reg <= wdata_i[enable_bit];
        chan_reg <= wdata_i[chan_lsb +: 5]; // R02
        go_reg <= wdata_i[go_bit] && wdata_i[enable_bit];
      end else if (finish || sleep_kill || !converter_enable_reg) begin
        go_reg <= 1'b0; // R17
      end
      if (wr_i && addr_i == ctrl1_offset) begin
        pref_reg <= wdata_i[pref_lsb +: 2];
        csel_reg <= wdata_i[csel_lsb +: 3];
        result_justify_reg <= wdata_i[justify_bit];
      end
      if (wr_i && addr_i == flags_offset) begin
        conv_irq_enable_reg <= wdata_i[irq_en_bit];
      end
    end
  end

  // done flag: set wins over a software clear
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conv_done_flag_reg <= 1'b0;
    end else if (finish) begin
      conv_done_flag_reg <= 1'b1; // R10
    end else if (wr_i && addr_i == flags_offset && !wdata_i[done_bit]) begin
      conv_done_flag_reg <= 1'b0; // R11
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_reg <= 10'h000;
    end else if (finish) begin
      result_reg <= sar_reg; // R17
    end else if (abort) begin
      result_reg <= fill_partial(sar_reg, (bit_idx > 4'd10) ? 4'd10 :
        ((bit_idx == 4'd0) ? 4'd0 : bit_idx - 4'd1)); // R18
    end
  end

  assign pair = justify(result_reg, result_justify_reg); // R14 R19

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= reset_value;
    end else if (rd_i) begin
      case (addr_i)
        ctrl0_offset: rdata_o <= {1'b0, chan_reg, go_reg, converter_enable_reg};
        ctrl1_offset: rdata_o <= {result_justify_reg, csel_reg, 2'b00, pref_reg};
        res_hi_offset: rdata_o <= pair[15:8];
        res_lo_offset: rdata_o <= pair[7:0];
        flags_offset: rdata_o <= {5'h00, sleep_i, conv_irq_enable_reg, conv_done_flag_reg};
        default: rdata_o <= reset_value;
      endcase
    end else begin
      rdata_o <= reset_value;
    end
  end

  // ----------------------------------------------------------
  // analog front-end controls
  // ----------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      channel_select_o <= 5'h00;
      mux_connect_o <= 1'b0;
      pos_ref_select_o <= 2'b00;
      sample_o <= 1'b0;
      dac_o <= 10'h000;
      wake_o <= 1'b0;
    end else begin
      channel_select_o <= chan_reg; // R02
      mux_connect_o <= converter_enable_reg; // R03
      pos_ref_select_o <= (pref_reg == 2'b01) ? pref_supply : pref_reg; // R05
      sample_o <= converter_enable_reg && !running_reg;
      dac_o <= (running_reg && bit_idx >= 4'd1 && bit_idx <= 4'd10) ?
        (sar_reg | (10'h200 >> (bit_idx - 4'd1))) : 10'h000;
      wake_o <= finish && sleep_i && conv_irq_enable_reg; // R12
    end
  end

  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  property p_done_set;
    @(posedge clock_i) disable iff (!rst_n_i) finish |=> conv_done_flag_reg;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set"); // R10

  property p_flag_hold;
    @(posedge clock_i) disable iff (!rst_n_i)
      conv_done_flag_reg && !(wr_i && addr_i == flags_offset) |=> conv_done_flag_reg;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag cleared by hardware"); // R11

  property p_go_clear;
    @(posedge clock_i) disable iff (!rst_n_i) finish && !wr_i |=> !go_reg;
  endproperty
  a_go_clear: assert property (p_go_clear) else $error("status not cleared"); // R17

  property p_mux_off;
    @(posedge clock_i) disable iff (!rst_n_i) !converter_enable_reg |=> !mux_connect_o;
  endproperty
  a_mux_off: assert property (p_mux_off) else $error("mux connected while off"); // R03

  property p_wake;
    @(posedge clock_i) disable iff (!rst_n_i)
      finish && sleep_i && conv_irq_enable_reg |=> wake_o;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake request"); // R12

  property p_justify;
    @(posedge clock_i) disable iff (!rst_n_i)
      result_justify_reg |-> pair[15:10] == 6'h00 && pair[9:0] == result_reg;
  endproperty
  a_justify: assert property (p_justify) else $error("right justify wrong"); // R19

  property p_left;
    @(posedge clock_i) disable iff (!rst_n_i)
      !result_justify_reg |-> pair[5:0] == 6'h00 && pair[15:6] == result_reg;
  endproperty
  a_left: assert property (p_left) else $error("left justify wrong"); // R14

  property p_result;
    @(posedge clock_i) disable iff (!rst_n_i) finish |=> result_reg == $past(sar_reg);
  endproperty
  a_result: assert property (p_result) else $error("result not stored"); // R01

  property p_sleep;
    @(posedge clock_i) disable iff (!rst_n_i)
      sleep_i && csel_reg[1:0] != 2'b11 && running_reg |=> !running_reg;
  endproperty
  a_sleep: assert property (p_sleep) else $error("ran in sleep off rc"); // R13

  property p_start;
    @(posedge clock_i) disable iff (!rst_n_i)
      go_reg && !running_reg && converter_enable_reg && !sleep_kill |=> running_reg;
  endproperty
  a_start: assert property (p_start) else $error("conversion not started"); // R16

  property p_chan;
    @(posedge clock_i) disable iff (!rst_n_i)
      converter_enable_reg |=> channel_select_o == $past(chan_reg);
  endproperty
  a_chan: assert property (p_chan) else $error("channel not routed"); // R02

  property p_ref;
    @(posedge clock_i) disable iff (!rst_n_i)
      pref_reg != 2'b01 |=> pos_ref_select_o == $past(pref_reg);
  endproperty
  a_ref: assert property (p_ref) else $error("reference code not passed"); // R05

  property p_ref_odd;
    @(posedge clock_i) disable iff (!rst_n_i)
      pref_reg == 2'b01 |=> pos_ref_select_o == pref_supply;
  endproperty
  a_ref_odd: assert property (p_ref_odd) else $error("unused code not on supply"); // R05

  property p_abort_stop;
    @(posedge clock_i) disable iff (!rst_n_i)
      abort |=> !running_reg && !go_reg;
  endproperty
  a_abort_stop: assert property (p_abort_stop) else $error("abort did not stop"); // R18

  property p_length;
    @(posedge clock_i) disable iff (!rst_n_i)
      running_reg |-> phase_reg <= 5'(half_periods - 1);
  endproperty
  a_length: assert property (p_length) else $error("conversion overran"); // R07

  // in rc mode a half-period step only follows a synchronised rc edge
  property p_rc_tick;
    @(posedge clock_i) disable iff (!rst_n_i)
      running_reg && tick && ($past(csel_reg) & 3'b011) == 3'b011 |->
        $past(rc_s2_reg) != $past(rc_s3_reg);
  endproperty
  a_rc_tick: assert property (p_rc_tick) else $error("rc step without edge"); // R20

  c_finish: cover property (@(posedge clock_i) finish);
  c_abort: cover property (@(posedge clock_i) abort);
  c_wake: cover property (@(posedge clock_i) wake_o);
  c_sleep_kill: cover property (@(posedge clock_i) sleep_kill);
  c_rc_finish: cover property (@(posedge clock_i) finish && csel_reg[1:0] == 2'b11);
endmodule

// ---- verilog/sar_adc_pkg.sv ----
// Purpose: constants for the successive-approximation converter control
// Assumes: 20 MHz system clock, plain register port
// Notes: register offsets are word indices on the plain port
//
// Contract
// R01: 10-bit result stored in result pair
// R02: one of 32 channels drives sample-hold
// R03: converter disabled disconnects every mux input
// R04: software waits settling after channel change
// R05: 2-bit positive reference select, negative ground
// R06: 3-bit clock select divides or picks RC
// R07: conversion takes 11.5 bit periods
// R08: software picks adequate bit period
// R09: divided clock tracks system clock
// R10: done flag set on every conversion
// R11: only software clears done flag
// R12: enabled completion in sleep raises wake
// R13: sleep conversion only with RC clock
// R14: justify bit picks left or right
// R15: software configures pin analog first
// R16: status bit set while enabled starts conversion
// R17: completion clears status, sets flag, updates result
// R18: abort writes partial result, bits repeat last
// R19: left uses 15:6, right uses 9:0
// R20: RC events synchronised into system domain
package sar_adc_pkg;
  localparam logic [2:0] ctrl0_offset = 3'h0;
  localparam logic [2:0] ctrl1_offset = 3'h1;
  localparam logic [2:0] res_hi_offset = 3'h2;
  localparam logic [2:0] res_lo_offset = 3'h3;
  localparam logic [2:0] flags_offset = 3'h4;
  localparam int enable_bit = 0;
  localparam int go_bit = 1;
  localparam int chan_lsb = 2;
  localparam int pref_lsb = 0;
  localparam int csel_lsb = 4;
  localparam int justify_bit = 7;
  localparam int done_bit = 0;
  localparam int irq_en_bit = 1;
  localparam int sleep_bit = 2;
  localparam logic [7:0] reset_value = 8'h00;
  localparam int conv_bits = 10;
  localparam int half_periods = 23;
  localparam logic [1:0] pref_supply = 2'b00;
  localparam logic [1:0] pref_pin = 2'b10;
  localparam logic [1:0] pref_fixed = 2'b11;
  localparam logic [5:0] div_rc_sel = 6'h00;
  typedef enum logic [1:0] {ref_supply_type_s, ref_pin_s, ref_fixed_s, ref_none_s} ref_type;
endpackage

// ---- verilog/sar_clock_gen.sv ----
// Purpose: converter clock half-period tick generator
// Assumes: rc_tick_i is a synchronised one-cycle strobe
// Notes: tick_o marks each half bit period
`timescale 1ns/1ps
module sar_clock_gen (
  input wire logic clock_i, // system clock
  input wire logic rst_n_i, // async reset
  input wire logic [2:0] csel_i, // clock select code
  input wire logic rc_tick_i, // rc half-period strobe
  input wire logic run_i, // converter running
  output logic tick_o // half bit-period strobe
);
  import sar_adc_pkg::*;
  logic [5:0] cnt_reg;
  logic [5:0] lim;

  // half of the divide ratio minus one, in system clocks
  function automatic logic [5:0] half_limit(input logic [2:0] c);
    case (c)
      3'b000: half_limit = 6'h00;
      3'b100: half_limit = 6'h01;
      3'b001: half_limit = 6'h03;
      3'b101: half_limit = 6'h07;
      3'b010: half_limit = 6'h0f;
      3'b110: half_limit = 6'h1f;
      default: half_limit = div_rc_sel;
    endcase
  endfunction

  assign lim = half_limit(csel_i);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= 6'h00;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      cnt_reg <= 6'h00;
      tick_o <= 1'b0;
    end else if (csel_i[1:0] == 2'b11) begin
      tick_o <= rc_tick_i; // R13
    end else if (cnt_reg >= lim) begin
      cnt_reg <= 6'h00;
      tick_o <= 1'b1; // R06 R09
    end else begin
      cnt_reg <= cnt_reg + 6'h01;
      tick_o <= 1'b0;
    end
  end
endmodule
